/* core/conv_ctrl.sv */
// conversion start, approximation sequencing and output format control
// Summary of operation
// - format input high gives only the 12-bit parallel word.
// - format at ground gives byte/serial; serial clock stops after a frame.
// - format at negative supply gives byte/serial with free-running serial clock.
// - rising edge of convert_start_n with chip select high enters hold and starts a conversion.
// - convert_start_n is asynchronous and is synchronised before use.
// - chip select is active low; the parallel/byte read port answers only while selected.
// - with convert_start_n held low, each chip select fall starts a conversion.
// - chip-select-started conversions enter hold on the chip select fall.
// - results come from 12 successive-approximation steps, one bit each.
// - bipolar variants code results as twos complement.
// - unipolar variant codes straight binary, zero input gives zero.
// - bipolar extremes are 0111..1 and 1000..0; just below zero is all ones.
// - byte mode high byte is zero nibble plus top four bits, else low byte.
// - active-low status output shows conversion in progress.
// - serial data is valid at the serial clock fall while frame is low.
// - converter clock is internal when selected, else the external clock.
`timescale 1ns/1ps
module conv_ctrl
   import conv_ctrl_pkg::*;
#(
   parameter bit BIPOLAR = 1'b1
) (
   input  wire logic                            clock_i,
   input  wire logic                            rst_i,
   input  wire logic                            convert_start_n_i,
   input  wire logic                            chip_sel_n_i,
   input  wire logic                            read_n_i,
   input  wire logic [1:0]                      format_i,
   input  wire logic                            high_byte_sel_i,
   input  wire logic                            ext_clk_i,
   input  wire logic                            use_internal_clk_i,
   input  wire logic                            comparator_i,
   input  wire logic                            result_ready_i,
   output logic      [conv_ctrl_pkg::RESULT_W-1:0] dac_code_o,
   output logic                                 hold_o,
   output logic                                 busy_n_o,
   output logic      [conv_ctrl_pkg::RESULT_W-1:0] data_o,
   output logic                                 data_oe_o,
   output logic                                 result_valid_o,
   output logic                                 serial_clk_o,
   output logic                                 serial_clk_oe_o,
   output logic                                 serial_out_o,
   output logic                                 serial_out_oe_o,
   output logic                                 serial_frame_n_o,
   output logic                                 serial_frame_n_oe_o
);
   import conv_ctrl_pkg::*;

   conv_state_t          state;
   logic [1:0]           cs_sync;
   logic [1:0]           cv_sync;
   logic [1:0]           rd_sync;
   logic [1:0]           ck_sync;
   logic                 cs_d;
   logic                 cv_d;
   logic                 ck_d;
   logic                 cs_n;
   logic                 cv_n;
   logic                 ck_rise;
   logic [6:0]           div_cnt;
   logic                 int_tick;
   logic                 conv_tick;
   logic                 start;
   logic [RESULT_W-1:0]  approx_register;
   logic [3:0]           bit_idx;
   logic [9:0]           acq_cnt;
   logic [RESULT_W-1:0]  coded;
   logic                 buf_in_ready;
   logic [RESULT_W-1:0]  buf_data;
   logic                 buf_valid;
   logic                 buf_pop;
   logic [RESULT_W-1:0]  last_result;
   logic                 parallel_only;
   logic                 free_sclk;
   logic [FRAME_W-1:0]   shift;
   logic [4:0]           shift_cnt;
   logic                 sclk_phase;
   logic [1:0]           fmt_flags;
   logic                 step;
   logic [RESULT_W-1:0]  rd_word;

   // format flags, one decoder used for both
   function automatic logic [1:0] decode_fmt(input logic [1:0] f);
      unique case (f)
         FMT_POS: decode_fmt = 2'b10;
         FMT_NEG: decode_fmt = 2'b01;
         default: decode_fmt = 2'b00;               // ground and illegal code
      endcase
   endfunction

   assign fmt_flags     = decode_fmt(format_i);
   assign parallel_only = fmt_flags[1];
   assign free_sclk     = fmt_flags[0];

   // two flip-flop synchronisers for chip select, convert start, read and external clock inputs
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cs_sync <= 2'h3;
         cv_sync <= 2'h3;
         rd_sync <= 2'h3;
         ck_sync <= 2'h0;
      end else begin
         cs_sync <= {cs_sync[0], chip_sel_n_i};
         cv_sync <= {cv_sync[0], convert_start_n_i};
         rd_sync <= {rd_sync[0], read_n_i};
         ck_sync <= {ck_sync[0], ext_clk_i};
      end
   end
   assign cs_n = cs_sync[1];
   assign cv_n = cv_sync[1];

   // edge history, taken only from the second synchroniser stage
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cs_d <= 1'b1;
         cv_d <= 1'b1;
         ck_d <= 1'b0;
      end else begin
         cs_d <= cs_n;
         cv_d <= cv_n;
         ck_d <= ck_sync[1];
      end
   end
   assign ck_rise = ck_sync[1] && !ck_d;

   // internal oscillator stands in as a divider of the system clock
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         div_cnt <= 7'h00;
      end else if (div_cnt == 7'(CONV_DIV - 1)) begin
         div_cnt <= 7'h00;
      end else begin
         div_cnt <= div_cnt + 7'h01;
      end
   end
   assign int_tick  = (div_cnt == 7'(CONV_DIV - 1));
   assign conv_tick = use_internal_clk_i ? int_tick : ck_rise;
   // a step waits until the trial code has reached the comparator
   assign step = (state == ST_CONVERT) && conv_tick && (dac_code_o == approx_register);

   // start: convert_start rising edge, or chip select fall while it is held low;
   // a convert_start edge is ignored while chip select is low
   assign start = (state == ST_TRACK) &&
                  ((cv_n && !cv_d && cs_n) ||
                   (!cv_n && !cs_n && cs_d));

   // track, convert and acquire sequencing
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state   <= ST_TRACK;
         bit_idx <= 4'h0;
         acq_cnt <= 10'h000;
      end else begin
         unique case (state)
            ST_TRACK: begin
               if (start) begin
                  state   <= ST_CONVERT;
                  bit_idx <= 4'(RESULT_W - 1);
               end
            end
            ST_CONVERT: begin
               if (step) begin
                  if (bit_idx == 4'h0) begin
                     state   <= ST_ACQUIRE;
                     acq_cnt <= 10'(ACQ_CYC - 1);
                  end else begin
                     bit_idx <= bit_idx - 4'h1;
                  end
               end
            end
            ST_ACQUIRE: begin
               // a start inside the spacing time is the host's fault; it is dropped
               if (acq_cnt == 10'h000) begin
                  state <= ST_TRACK;
               end else begin
                  acq_cnt <= acq_cnt - 10'h001;
               end
            end
            default: state <= ST_TRACK;
         endcase
      end
   end

   // successive approximation: trial bit set, kept or dropped per comparator
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         approx_register <= RESULT_RESET;
      end else if (start) begin
         approx_register <= RESULT_W'(1) << (RESULT_W - 1);
      end else if (step) begin
         approx_register[bit_idx] <= comparator_i;
         if (bit_idx != 4'h0) begin
            approx_register[bit_idx - 4'h1] <= 1'b1;
         end
      end
   end

   // binary offset from the comparator to twos complement for bipolar parts
   assign coded = BIPOLAR ? (approx_register ^ BIPOLAR_OFFSET)
                          : approx_register;

   // results queue holds two words for a stalled reader; a third result is dropped
   result_buffer #(
      .WIDTH(RESULT_W)
   ) u_buf (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .in_data_i   ({coded[RESULT_W-1:1], comparator_i}),   // last bit lands this cycle
      .in_valid_i  (step && bit_idx == 4'h0),
      .in_ready_o  (buf_in_ready),
      .out_data_o  (buf_data),
      .out_valid_o (buf_valid),
      .out_ready_i (result_ready_i)
   );
   assign buf_pop = buf_valid && result_ready_i;
   assign rd_word = buf_valid ? buf_data : last_result;   // oldest unread result first

   // outputs of the converter core and status
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         dac_code_o     <= RESULT_RESET;
         hold_o         <= 1'b0;
         busy_n_o       <= 1'b1;
         last_result    <= RESULT_RESET;
         result_valid_o <= 1'b0;
      end else begin
         dac_code_o     <= approx_register;
         hold_o         <= (state == ST_CONVERT) || start;
         busy_n_o       <= !((state == ST_CONVERT) || start);
         result_valid_o <= buf_valid;
         if (buf_pop) begin
            last_result <= buf_data;
         end
      end
   end

   // parallel and byte read port; drives only while selected and reading
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         data_o    <= RESULT_RESET;
         data_oe_o <= 1'b0;
      end else begin
         data_oe_o <= !cs_n && !rd_sync[1] && (state != ST_CONVERT);
         if (parallel_only) begin
            data_o <= rd_word;
         end else if (high_byte_sel_i) begin
            data_o <= {{(RESULT_W - NIBBLE_W){1'b0}},
                       rd_word[RESULT_W-1 -: NIBBLE_W]};
         end else begin
            data_o <= {{(RESULT_W - BYTE_W){1'b0}}, rd_word[BYTE_W-1:0]};
         end
      end
   end

   // serial frame: loaded at start, shifted on every second converter tick until the frame ends;
   // the previous result goes out while the new one is resolved
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         shift     <= '0;
         shift_cnt <= 5'h00;
      end else if (start && !parallel_only) begin
         shift     <= {{LEAD_ZEROS{1'b0}}, last_result};
         shift_cnt <= 5'(FRAME_W + 1);
      end else if (shift_cnt != 5'h00 && conv_tick && !sclk_phase) begin
         // bits move on the rise; the first rise only opens the frame
         if (shift_cnt != 5'(FRAME_W + 1)) begin
            shift <= {shift[FRAME_W-2:0], 1'b0};
         end
         shift_cnt <= shift_cnt - 5'h01;
      end
   end

   // serial clock: half period per converter tick; low half holds a stable bit
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sclk_phase <= 1'b0;
      end else if (conv_tick) begin
         sclk_phase <= ~sclk_phase;
      end
   end

   // open-drain serial pins; enable high pulls the line low
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         serial_clk_o        <= 1'b0;
         serial_clk_oe_o     <= 1'b0;
         serial_out_o        <= 1'b0;
         serial_out_oe_o     <= 1'b0;
         serial_frame_n_o    <= 1'b0;
         serial_frame_n_oe_o <= 1'b0;
      end else begin
         serial_clk_oe_o     <= !parallel_only && !sclk_phase &&
                                (free_sclk || shift_cnt != 5'h00);
         serial_out_oe_o     <= !parallel_only && shift_cnt != 5'h00 &&
                                !shift[FRAME_W-1];
         serial_frame_n_oe_o <= !parallel_only && shift_cnt != 5'h00 &&
                                shift_cnt != 5'(FRAME_W + 1);
      end
   end
endmodule // conv_ctrl

/* core/conv_ctrl_pkg.sv */
// constants shared by the conversion control block
package conv_ctrl_pkg;
   localparam int          RESULT_W       = 12;
   localparam int          FRAME_W        = 16;
   localparam int          LEAD_ZEROS     = FRAME_W - RESULT_W;
   localparam int          BYTE_W         = 8;
   localparam int          NIBBLE_W       = 4;
   localparam int          CLK_MHZ        = 200;
   // nominal converter clock 2.5 MHz -> divide 200 MHz by 80
   localparam int          CONV_CLK_KHZ   = 2500;
   localparam int          CONV_DIV       = (CLK_MHZ * 1000) / CONV_CLK_KHZ;
   // acquisition time after conversion, 2 us
   localparam int          ACQ_NS         = 2000;
   localparam int          ACQ_CYC        = (ACQ_NS * CLK_MHZ + 999) / 1000;
   // three-level format input codes
   localparam logic [1:0]  FMT_POS        = 2'h2;   // +5 V: parallel only
   localparam logic [1:0]  FMT_GND        = 2'h0;   // 0 V: byte/serial, gated clock
   localparam logic [1:0]  FMT_NEG        = 2'h1;   // -5 V: byte/serial, free clock
   localparam logic [11:0] BIPOLAR_OFFSET = 12'h800;
   localparam logic [11:0] RESULT_RESET   = 12'h000;
   typedef enum logic [1:0] {
      ST_TRACK   = 2'b00,
      ST_CONVERT = 2'b01,
      ST_ACQUIRE = 2'b10
   } conv_state_t;
endpackage

/* core/result_buffer.sv */
// two-entry buffer for finished conversion results
`timescale 1ns/1ps
module result_buffer #(
   parameter int WIDTH = 12
) (
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   logic [WIDTH-1:0] mem [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       count;
   logic             push;
   logic             pop;

   assign push        = in_valid_i && (count != 2'h2);
   assign pop         = out_valid_o && out_ready_i;
   assign in_ready_o  = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_data_o  = mem[rd_ptr];

   // storage and pointers; pop and push may share a cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // result_buffer

/* testbench/conv_ctrl_sva.sv */
// assertion checker for the conversion control block
`timescale 1ns/1ps
module conv_ctrl_sva
   import conv_ctrl_pkg::*;
(
   input wire logic       clock_i,
   input wire logic       rst_i,
   input wire logic       convert_start_n_i,
   input wire logic       chip_sel_n_i,
   input wire logic [1:0] format_i,
   input wire logic       high_byte_sel_i,
   input wire logic       ext_clk_i,
   input wire logic       use_internal_clk_i,
   input wire logic       hold_o,
   input wire logic       busy_n_o,
   input wire logic [conv_ctrl_pkg::RESULT_W-1:0] data_o,
   input wire logic       data_oe_o,
   input wire logic       serial_clk_oe_o,
   input wire logic       serial_out_oe_o,
   input wire logic       serial_frame_n_oe_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic busy_q, ext_q, idle;
   int   conv_cyc, ext_cnt, idle_cnt;
   // cycles and external ticks per conversion, idle time since the last one
   always_ff @(posedge clock_i) begin
      busy_q <= busy_n_o;
      ext_q <= ext_clk_i;
      conv_cyc <= (rst_i || busy_q) ? 0 : conv_cyc + 1;
      ext_cnt <= (rst_i || busy_q) ? 0 : ext_cnt + int'(ext_clk_i && !ext_q);
      idle_cnt <= rst_i ? 1000 : !busy_n_o ? 0 : (idle_cnt < 1000) ? idle_cnt + 1 : idle_cnt;
   end
   // margin past the acquisition time covers the pin synchroniser lag
   assign idle = idle_cnt > 420 && !hold_o;
   sequence s_started;
      ##[3:5] (hold_o && !busy_n_o);
   endsequence
   sequence s_hb_steady;
      (high_byte_sel_i && format_i != FMT_POS)[*6];
   endsequence
   a_parallel_only: assert property ((format_i == FMT_POS)[*4] |->
      !(serial_clk_oe_o || serial_out_oe_o || serial_frame_n_oe_o))
      else $error("serial pin driven in parallel format");
   a_start_hold: assert property ($rose(convert_start_n_i) && chip_sel_n_i && idle |-> s_started)
      else $error("start edge did not enter hold");
   a_cs_start: assert property ($fell(chip_sel_n_i) && !convert_start_n_i && idle |-> s_started)
      else $error("select fall did not start a conversion");
   a_conv_ticks: assert property ($rose(busy_n_o) |-> (use_internal_clk_i ?
      (conv_cyc inside {[870:1000]}) : (ext_cnt inside {[11:13]})))
      else $error("conversion length not twelve converter ticks");
   a_status_hold: assert property ($fell(busy_n_o) |-> hold_o ##1 (!busy_n_o && hold_o)[*8])
      else $error("status and hold disagree");
   a_desel_quiet: assert property (chip_sel_n_i[*6] |-> !data_oe_o)
      else $error("data driven while deselected");
   a_byte_high: assert property (s_hb_steady ##0 data_oe_o |-> data_o[7:4] == 4'h0)
      else $error("upper nibble of high byte not zero");
   a_sclk_free: assert property ((format_i == FMT_NEG)[*8] |-> ##[0:200] $changed(serial_clk_oe_o))
      else $error("serial clock stopped in continuous format");
endmodule // conv_ctrl_sva

bind conv_ctrl conv_ctrl_sva u_sva (.clock_i(clock_i), .rst_i(rst_i),
   .convert_start_n_i(convert_start_n_i), .chip_sel_n_i(chip_sel_n_i), .format_i(format_i),
   .high_byte_sel_i(high_byte_sel_i), .ext_clk_i(ext_clk_i),
   .use_internal_clk_i(use_internal_clk_i), .hold_o(hold_o), .busy_n_o(busy_n_o),
   .data_o(data_o), .data_oe_o(data_oe_o), .serial_clk_oe_o(serial_clk_oe_o),
   .serial_out_oe_o(serial_out_oe_o), .serial_frame_n_oe_o(serial_frame_n_oe_o));

/* testbench/analog_cmp_model.sv */
// comparator stand-in that holds the analog level while the design holds
`timescale 1ns/1ps
module analog_cmp_model
   import conv_ctrl_pkg::*;
(
   input  wire logic                                clock_i,
   input  wire logic                                hold_i,
   input  wire logic [conv_ctrl_pkg::RESULT_W-1:0] level_i,
   input  wire logic [conv_ctrl_pkg::RESULT_W-1:0] dac_code_i,
   output logic                                     comparator_o
);
   logic [RESULT_W-1:0] held;
   // freeze the level in hold so later input moves cannot leak into the result
   always_ff @(posedge clock_i) begin
      if (!hold_i) held <= level_i;
   end
   // keep a trial bit while the trial code does not exceed the held level
   assign comparator_o = dac_code_i <= held;
endmodule // analog_cmp_model

/* testbench/conv_ctrl_tb_top.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module conv_ctrl_tb_top;
   import conv_ctrl_pkg::*;
   logic        clock_i = 0, rst_i = 1, cs_n = 1, st_n = 1, rd_n = 1, hbs = 0;
   logic        ext = 0, int_clk = 0, rdy = 0, got = 0, sck_q = 1, cmp;
   logic        hold, busy_n, doe, rv, sck, sck_oe, so, so_oe, sf, sf_oe;
   logic [1:0]  fmt = FMT_POS;
   logic [11:0] level = 0, dac, data, last = 0, tab [3] = '{12'hfff, 12'h000, 12'h7ff};
   logic [11:0] exp_q [$], msk_q [$];
   logic [15:0] ser_q [$], sh = 0;
   int          errors = 0, cmp_count = 0, cyc = 0, nb = 0;
   // open-drain lines with pull-ups
   wire         sck_l = sck_oe ? sck : 1'b1;
   wire         so_l = so_oe ? so : 1'b1;
   wire         sf_l = sf_oe ? sf : 1'b1;

   conv_ctrl #(.BIPOLAR(1'b1)) DUT (.clock_i(clock_i), .rst_i(rst_i),
      .convert_start_n_i(st_n), .chip_sel_n_i(cs_n), .read_n_i(rd_n), .format_i(fmt),
      .high_byte_sel_i(hbs), .ext_clk_i(ext), .use_internal_clk_i(int_clk),
      .comparator_i(cmp), .result_ready_i(rdy), .dac_code_o(dac), .hold_o(hold),
      .busy_n_o(busy_n), .data_o(data), .data_oe_o(doe), .result_valid_o(rv),
      .serial_clk_o(sck), .serial_clk_oe_o(sck_oe), .serial_out_o(so),
      .serial_out_oe_o(so_oe), .serial_frame_n_o(sf), .serial_frame_n_oe_o(sf_oe));
   analog_cmp_model u_cmp (.clock_i(clock_i), .hold_i(hold), .level_i(level),
      .dac_code_i(dac), .comparator_o(cmp));

   always #2.5 clock_i = ~clock_i;
   // fast external converter clock, a tick every four cycles keeps the run short
   always @(negedge clock_i) if (cyc[0]) ext <= ~ext;
   // hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic report_and_stop();
      if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic wait_busy(input logic v);
      int n = 0;
      while (busy_n !== v && n < 3000) begin
         @(negedge clock_i);
         n++;
      end
      check({15'h0, busy_n}, {15'h0, v});
   endtask

   // one conversion; mode 2 holds start low and starts with the select fall
   task automatic convert(input logic m2, input logic [1:0] f, input logic [11:0] lv);
      @(negedge clock_i);
      fmt <= f;
      level <= lv;
      if (f != FMT_POS) ser_q.push_back({4'h0, last});
      repeat (8) @(negedge clock_i);
      st_n <= 0;
      @(negedge clock_i);
      if (m2) cs_n <= 0;
      else st_n <= 1;
      wait_busy(0);
      level <= 12'($urandom);
      if (!m2) st_n <= 0; // a second start mid-conversion must be dropped
      @(negedge clock_i);
      st_n <= 1;
      wait_busy(1);
      last = lv ^ 12'h800;
      repeat (4) @(negedge clock_i);
      cs_n <= 1;
      repeat (600) @(negedge clock_i);
   endtask

   task automatic read_word(input logic [11:0] e, m, input logic hb, pop);
      @(negedge clock_i);
      hbs <= hb;
      exp_q.push_back(e);
      msk_q.push_back(m);
      repeat (8) @(negedge clock_i);
      cs_n <= 0;
      rd_n <= 0;
      repeat (10) @(negedge clock_i);
      cs_n <= 1;
      rd_n <= 1;
      repeat (8) @(negedge clock_i);
      rdy <= pop;
      @(negedge clock_i);
      rdy <= 0;
   endtask

   // reads the head word; in byte formats it pops after the low byte only
   task automatic read_res(input logic [1:0] f, input logic [11:0] r);
      fmt <= f;
      if (f == FMT_POS) read_word(r, 12'hfff, 0, 1);
      else begin
         read_word({8'h0, r[11:8]}, 12'h0ff, 1, 0);
         read_word({4'h0, r[7:0]}, 12'h0ff, 0, 1);
      end
      repeat (4) @(negedge clock_i);
   endtask

   // compare each read word and each serial frame with the oldest note
   always @(negedge clock_i) begin
      if (doe !== 1'b1) got <= 0;
      else if (!got && exp_q.size() > 0) begin
         check({4'h0, data & msk_q.pop_front()}, {4'h0, exp_q.pop_front()});
         got <= 1;
      end
      sck_q <= sck_l;
      if (sf_l !== 1'b0) nb = 0;
      else if (sck_q && !sck_l) begin
         sh = {sh[14:0], so_l};
         nb++;
         if (nb == 16 && ser_q.size() > 0) check(sh, ser_q.pop_front());
      end
   end

   initial begin
      logic [11:0] a, lv;
      logic [1:0]  f;
      a = 12'($urandom(32'h32259627));
      repeat (8) @(posedge clock_i);
      @(negedge clock_i);
      rst_i <= 0;
      int_clk <= 1;
      convert(0, FMT_POS, 12'h800);
      read_res(FMT_POS, 12'h000);
      int_clk <= 0;
      for (int i = 0; i < 9; i++) begin
         lv = (i < 3) ? tab[i] : 12'($urandom);
         f = (i % 3 == 0) ? FMT_POS : (i % 3 == 1) ? FMT_GND : FMT_NEG;
         convert(i[0], f, lv);
         read_res(f, lv ^ 12'h800);
      end
      // two results wait in the buffer while the reader stalls
      convert(1, FMT_POS, a);
      lv = 12'($urandom);
      convert(0, FMT_POS, lv);
      check({15'h0, rv}, 16'h1);
      read_res(FMT_POS, a ^ 12'h800);
      read_res(FMT_POS, lv ^ 12'h800);
      check({15'h0, rv}, 16'h0);
      check(16'(ser_q.size() + exp_q.size()), 16'h0);
      report_and_stop();
   end
endmodule // conv_ctrl_tb_top
